//--- verilog/mgp_defs.svh
// Named constants for the PHY-side MII/GMII block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef MGP_DEFS_SVH
`define MGP_DEFS_SVH

// System clock and the three MII/GMII clock rates, in kHz
`define MGP_CLK_KHZ        200000
`define MGP_F10_KHZ        2500
`define MGP_F100_KHZ       25000
`define MGP_F1000_KHZ      125000

// Width of the clock divider counter
`define MGP_DIV_W          8

// Speed codes as they arrive on the configuration pins
`define MGP_SPD_CODE_10    2'h0
`define MGP_SPD_CODE_100   2'h1

// Field positions inside the synchronised pin vector
`define MGP_SY_W           18
`define MGP_SY_GTX         0
`define MGP_SY_TXER        1
`define MGP_SY_TXEN        2
`define MGP_SY_TXD_LO      3
`define MGP_SY_TXD_HI      10
`define MGP_SY_MDIX        11
`define MGP_SY_ANSPD_LO    12
`define MGP_SY_ANSPD_HI    13
`define MGP_SY_ANDONE      14
`define MGP_SY_ANEN        15
`define MGP_SY_FSPD_LO     16
`define MGP_SY_FSPD_HI     17

// Data lane layout
`define MGP_NIB_LO_HI      3
`define MGP_NIB_HI_LO      4
`define MGP_NIB_HI_HI      7
`define MGP_NIB_PAD        4'h0
`define MGP_BYTE_ZERO      8'h00

`endif

//--- verilog/mgp_pkg.sv
// Types shared by the PHY-side MII/GMII block.
// Assumes nothing beyond a SystemVerilog compiler.
package mgp_pkg;

    // Resolved link speed
    typedef enum logic [1:0] {
        SPD_10,
        SPD_100,
        SPD_1000
    } mgp_speed_t;

    // Line coding chosen for the shared drivers
    typedef enum logic [1:0] {
        COD_MANCHESTER,
        COD_MLT3,
        COD_PAM5
    } mgp_coding_t;

    // Class of each symbol handed to the line encoder
    typedef enum logic [1:0] {
        SYM_IDLE,
        SYM_DATA,
        SYM_INVALID,
        SYM_HALT
    } mgp_sym_t;

endpackage : mgp_pkg

//--- verilog/mgp_clk_if.sv
// Carrier between the MII clock generator and the main block.
// Assumes both ends run on the same system clock.
interface mgp_clk_if;
    import mgp_pkg::*;

    mgp_speed_t speed;
    logic       tx_clk;
    logic       rx_clk;
    logic       tx_fall;
    logic       rx_fall;

    modport gen (input speed, output tx_clk, rx_clk, tx_fall, rx_fall);
    modport use_side (output speed, input tx_clk, rx_clk, tx_fall, rx_fall);
endinterface : mgp_clk_if

//--- verilog/mgp_clk_gen.sv
// MII transmit and receive clock generator by division of clk.
// Assumes clk at MGP_CLK_KHZ; speed comes already resolved and registered.
`include "mgp_defs.svh"
module mgp_clk_gen (
    input wire logic clk,
    input wire logic reset_n,
    mgp_clk_if.gen   cif
);
    import mgp_pkg::*;

    // Half periods; a rate above half of clk falls to one cycle
    localparam int H10_I   = `MGP_CLK_KHZ / (2 * `MGP_F10_KHZ);
    localparam int H100_I  = `MGP_CLK_KHZ / (2 * `MGP_F100_KHZ);
    localparam int H1000_I = `MGP_CLK_KHZ / (2 * `MGP_F1000_KHZ);
    localparam logic [`MGP_DIV_W-1:0] H10 =
        `MGP_DIV_W'(H10_I < 1 ? 1 : H10_I);
    localparam logic [`MGP_DIV_W-1:0] H100 =
        `MGP_DIV_W'(H100_I < 1 ? 1 : H100_I);
    localparam logic [`MGP_DIV_W-1:0] H1000 =
        `MGP_DIV_W'(H1000_I < 1 ? 1 : H1000_I);
    localparam logic [`MGP_DIV_W-1:0] ONE = `MGP_DIV_W'(1);

    logic [`MGP_DIV_W-1:0] cnt;
    mgp_speed_t            speed_q;
    wire logic [`MGP_DIV_W-1:0] half;
    wire logic                  gig;
    wire logic                  wrap;

    // Divider selection
    assign gig  = (cif.speed == SPD_1000);
    assign half = gig ? H1000 : (cif.speed == SPD_100) ? H100 : H10;
    assign wrap = (cnt == half - ONE);

    // Both clocks share one divider; a speed change restarts it cleanly
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt         <= '0;
            speed_q     <= SPD_10;
            cif.rx_clk  <= 1'b0;
            cif.tx_clk  <= 1'b0;
            cif.rx_fall <= 1'b0;
            cif.tx_fall <= 1'b0;
        end else begin
            speed_q     <= cif.speed;
            cif.rx_fall <= 1'b0;
            cif.tx_fall <= 1'b0;
            if (speed_q != cif.speed) begin
                cnt        <= '0;
                cif.rx_clk <= 1'b0;
                cif.tx_clk <= 1'b0;
            end else if (wrap) begin
                cnt         <= '0;
                cif.rx_clk  <= ~cif.rx_clk;               // RL5
                cif.rx_fall <= cif.rx_clk;
                cif.tx_clk  <= gig ? 1'b0 : ~cif.tx_clk;  // RL13
                cif.tx_fall <= cif.tx_clk & ~gig;
            end else begin
                cnt <= cnt + ONE;
            end
        end
    end
endmodule : mgp_clk_gen

//--- verilog/mgp_mii_phy.sv
// PHY-side MII/GMII block: transmit error coding, receive presentation,
// line coding and pair selection per speed.
// Assumes MAC pins and strap/config pins are asynchronous to clk and that
// the symbol recovery logic on the receive side runs on clk.
//
// Summary of operation
// RL1: At 100 and 1000 Mb/s TX_ER high makes invalid line symbols.
// RL2: MAC drives TX_ER in step with TX_CLK or GTX_CLK.
// RL3: At 100 Mb/s an error gives one invalid symbol, then Halt while held.
// RL4: At 1000 Mb/s each errored byte becomes a non-data code-group.
// RL5: RX_CLK runs at 2.5, 25 or 125 MHz by speed; at 1000 the divider gives one-cycle half periods, 100 MHz.
// RL6: Receive data goes out as nibbles at 10/100, bytes at 1000.
// RL7: RX_DV is high exactly while valid receive data is presented.
// RL8: RX_ER follows detected receive errors at 100 and 1000 Mb/s.
// RL9: Coding is Manchester, MLT-3 or PAM-5 by speed.
// RL10: Drivers follow forced speed or the auto-negotiation result.
// RL11: 10/100 uses pair A or B per crossover; pairs C, D idle.
// RL12: Transmit data is taken only while TX_EN is high.
// RL13: TX_CLK runs at 2.5 or 25 MHz for 10/100.
// RL14: MAC supplies a continuous 125 MHz GTX_CLK in gigabit mode; the bench MAC model runs it at 8 MHz.
// RL15: At 10 Mb/s RX_ER stays low and TX_ER is ignored.
`include "mgp_defs.svh"
module mgp_mii_phy (
    input  wire logic               clk,
    input  wire logic               reset_n,
    // Speed configuration pins
    input  wire logic [1:0]         speed_forced,
    input  wire logic               an_enable,
    input  wire logic               an_done,
    input  wire logic [1:0]         an_speed,
    input  wire logic               mdix,
    // MAC transmit side
    input  wire logic               gtx_clk,
    input  wire logic [7:0]         mii_txd,
    input  wire logic               mii_tx_en,
    input  wire logic               mii_tx_er,
    output logic                    mii_tx_clk,
    // MAC receive side
    output logic                    mii_rx_clk,
    output logic [7:0]              mii_rxd,
    output logic                    mii_rx_dv,
    output logic                    mii_rx_er,
    // From symbol recovery
    input  wire logic               rx_sym_valid,
    input  wire logic [7:0]         rx_sym_data,
    input  wire logic               rx_sym_err,
    output logic                    rx_sym_ready,
    // To line encoder and drivers
    output logic                    tx_sym_valid,
    output logic [7:0]              tx_sym_data,
    output mgp_pkg::mgp_sym_t       tx_sym_class,
    output mgp_pkg::mgp_coding_t    line_coding,
    output logic                    line_pair_a_tx_pos_en,
    output logic                    line_pair_b_tx_pos_en,
    output logic                    line_pair_a_rx_pos_sel,
    output logic                    line_pair_b_rx_pos_sel,
    output logic                    line_pair_c_en,
    output logic                    line_pair_d_en
);
    import mgp_pkg::*;

    mgp_clk_if cif ();

    logic [`MGP_SY_W-1:0] sy1;
    logic [`MGP_SY_W-1:0] sy2;
    logic                 gtx_q;
    mgp_speed_t           speed;
    logic                 er_seen;
    logic [7:0]           rx_hold;
    logic                 rx_hold_err;
    logic                 rx_full;
    logic                 nib_hi;

    wire logic [`MGP_SY_W-1:0] pins;
    wire logic        s_gtx;
    wire logic        s_tx_er;
    wire logic        s_tx_en;
    wire logic [7:0]  s_txd;
    wire logic        s_mdix;
    wire logic [1:0]  s_an_speed;
    wire logic        s_an_done;
    wire logic        s_an_en;
    wire logic [1:0]  s_fspd;
    wire logic [1:0]  spd_code;
    wire mgp_speed_t  spd_decoded;
    wire logic        is10;
    wire logic        is100;
    wire logic        gig;
    wire logic        gtx_fall;
    wire logic        tx_take;
    wire logic        rx_take;
    wire logic        rx_present;
    wire logic        next_full;
    wire logic [7:0]  rx_lane;

    // Divided MII clocks
    mgp_clk_gen u_clk_gen (
        .clk     (clk),
        .reset_n (reset_n),
        .cif     (cif.gen)
    );

    // Pin vector; every asynchronous input passes two flops before use
    assign pins = {speed_forced, an_enable, an_done, an_speed, mdix,
                   mii_txd, mii_tx_en, mii_tx_er, gtx_clk};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sy1   <= '0;
            sy2   <= '0;
            gtx_q <= 1'b0;
        end else begin
            sy1   <= pins;
            sy2   <= sy1;
            gtx_q <= sy2[`MGP_SY_GTX];
        end
    end

    // Field split of the synchronised pins
    assign s_gtx      = sy2[`MGP_SY_GTX];
    assign s_tx_er    = sy2[`MGP_SY_TXER];
    assign s_tx_en    = sy2[`MGP_SY_TXEN];
    assign s_txd      = sy2[`MGP_SY_TXD_HI:`MGP_SY_TXD_LO];
    assign s_mdix     = sy2[`MGP_SY_MDIX];
    assign s_an_speed = sy2[`MGP_SY_ANSPD_HI:`MGP_SY_ANSPD_LO];
    assign s_an_done  = sy2[`MGP_SY_ANDONE];
    assign s_an_en    = sy2[`MGP_SY_ANEN];
    assign s_fspd     = sy2[`MGP_SY_FSPD_HI:`MGP_SY_FSPD_LO];

    // Speed source: forced pins, or auto-negotiation once it is done
    assign spd_code    = s_an_en ? s_an_speed : s_fspd;
    assign spd_decoded = (spd_code == `MGP_SPD_CODE_10)  ? SPD_10 :
                         (spd_code == `MGP_SPD_CODE_100) ? SPD_100 :
                                                           SPD_1000;

    // Holding the last speed while negotiation runs avoids driver churn
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            speed <= SPD_10;
        end else if (!s_an_en || s_an_done) begin
            speed <= spd_decoded;                       // RL10
        end
    end

    assign cif.speed = speed;
    assign is10  = (speed == SPD_10);
    assign is100 = (speed == SPD_100);
    assign gig   = (speed == SPD_1000);

    // Driver configuration and pair use; mdix swaps A and B
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_coding            <= COD_MANCHESTER;
            line_pair_a_tx_pos_en  <= 1'b0;
            line_pair_b_tx_pos_en  <= 1'b0;
            line_pair_a_rx_pos_sel <= 1'b0;
            line_pair_b_rx_pos_sel <= 1'b0;
            line_pair_c_en         <= 1'b0;
            line_pair_d_en         <= 1'b0;
        end else begin
            line_coding <= gig ? COD_PAM5 :
                           is100 ? COD_MLT3 : COD_MANCHESTER;  // RL9
            line_pair_a_tx_pos_en  <= gig | ~s_mdix;           // RL11
            line_pair_b_tx_pos_en  <= gig | s_mdix;            // RL11
            line_pair_a_rx_pos_sel <= gig | s_mdix;            // RL11
            line_pair_b_rx_pos_sel <= gig | ~s_mdix;           // RL11
            line_pair_c_en         <= gig;                     // RL11
            line_pair_d_en         <= gig;                     // RL11
        end
    end

    // Sample MAC signals mid-period, well clear of the launching edge
    assign gtx_fall = gtx_q & ~s_gtx;
    assign tx_take  = gig ? gtx_fall : cif.tx_fall;    // RL2 RL14

    // Transmit symbol classification per speed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_sym_valid <= 1'b0;
            tx_sym_data  <= `MGP_BYTE_ZERO;
            tx_sym_class <= SYM_IDLE;
            er_seen      <= 1'b0;
        end else begin
            tx_sym_valid <= tx_take;
            if (tx_take) begin
                tx_sym_data <= !s_tx_en ? `MGP_BYTE_ZERO :
                               gig ? s_txd :
                               {`MGP_NIB_PAD,
                                s_txd[`MGP_NIB_LO_HI:0]};  // RL12
                if (s_tx_er && is100) begin
                    tx_sym_class <= er_seen ? SYM_HALT
                                            : SYM_INVALID;  // RL1 RL3
                    er_seen      <= 1'b1;
                end else if (s_tx_er && gig) begin
                    tx_sym_class <= SYM_INVALID;            // RL1 RL4
                    er_seen      <= 1'b0;
                end else begin
                    // 10 Mb/s lands here even with TX_ER high
                    tx_sym_class <= s_tx_en ? SYM_DATA
                                            : SYM_IDLE;     // RL12 RL15
                    er_seen      <= 1'b0;
                end
            end
        end
    end

    // Receive hand-off: one byte held, split into two nibbles below 1000
    assign rx_take    = rx_sym_valid & rx_sym_ready;
    assign rx_present = cif.rx_fall & rx_full;
    assign next_full  = rx_take | (rx_full & ~(rx_present & (gig | nib_hi)));
    assign rx_lane    = gig ? rx_hold :
                        nib_hi ? {`MGP_NIB_PAD,
                                  rx_hold[`MGP_NIB_HI_HI:`MGP_NIB_HI_LO]} :
                                 {`MGP_NIB_PAD,
                                  rx_hold[`MGP_NIB_LO_HI:0]};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_hold      <= `MGP_BYTE_ZERO;
            rx_hold_err  <= 1'b0;
            rx_full      <= 1'b0;
            rx_sym_ready <= 1'b0;
        end else begin
            rx_full      <= next_full;
            rx_sym_ready <= ~next_full;
            if (rx_take) begin
                rx_hold     <= rx_sym_data;
                rx_hold_err <= rx_sym_err;
            end
        end
    end

    // Outputs change on the RX_CLK falling edge, so the MAC samples on rise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mii_rxd   <= `MGP_BYTE_ZERO;
            mii_rx_dv <= 1'b0;
            mii_rx_er <= 1'b0;
            nib_hi    <= 1'b0;
        end else if (cif.rx_fall) begin
            mii_rxd   <= rx_full ? rx_lane : `MGP_BYTE_ZERO;  // RL6
            mii_rx_dv <= rx_full;                             // RL7
            mii_rx_er <= rx_full & rx_hold_err & ~is10;       // RL8 RL15
            nib_hi    <= rx_full & ~gig & ~nib_hi;            // RL6
        end
    end

    // Clock pins taken from the divider flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mii_tx_clk <= 1'b0;
            mii_rx_clk <= 1'b0;
        end else begin
            mii_tx_clk <= cif.tx_clk;                         // RL13
            mii_rx_clk <= cif.rx_clk;                         // RL5
        end
    end
endmodule : mgp_mii_phy

//--- tb/mgp_mac_model.sv
// MAC model: gigabit transmit clock and the transmit pins.
// Assumes the bench sets the next symbol between launch edges.
module mgp_mac_model (
    input  wire logic       mii_tx_clk,
    input  wire logic       gig,
    input  wire logic [7:0] nx_txd,
    input  wire logic       nx_en,
    input  wire logic       nx_er,
    output logic            gtx_clk,
    output logic [7:0]      mii_txd,
    output logic            mii_tx_en,
    output logic            mii_tx_er
);
    timeunit 1ns;
    timeprecision 100ps;
    // Free-running, never gated, like a real MAC reference
    initial gtx_clk = 1'b0;
    always #62.5 gtx_clk = ~gtx_clk;
    initial {mii_txd, mii_tx_en, mii_tx_er} = '0;
    // Launch on the rise so the PHY captures half a period later
    task automatic launch;
        mii_txd <= nx_txd;
        mii_tx_en <= nx_en;
        mii_tx_er <= nx_er;
    endtask : launch
    always @(posedge mii_tx_clk) if (!gig) launch;
    always @(posedge gtx_clk) if (gig) launch;
endmodule : mgp_mac_model

//--- tb/mgp_phy_properties.sv
// Port checker for the PHY-side MII/GMII block.
// Assumes it is bound into mgp_mii_phy and sees only its ports.
module mgp_phy_properties (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire mgp_pkg::mgp_coding_t line_coding,
    input wire logic                 line_pair_a_tx_pos_en,
    input wire logic                 line_pair_b_tx_pos_en,
    input wire logic                 line_pair_a_rx_pos_sel,
    input wire logic                 line_pair_b_rx_pos_sel,
    input wire logic                 line_pair_c_en,
    input wire logic                 line_pair_d_en,
    input wire logic                 mii_tx_clk,
    input wire logic                 mii_rx_clk,
    input wire logic [7:0]           mii_rxd,
    input wire logic                 mii_rx_dv,
    input wire logic                 mii_rx_er,
    input wire logic                 tx_sym_valid,
    input wire logic [7:0]           tx_sym_data,
    input wire mgp_pkg::mgp_sym_t    tx_sym_class
);
    import mgp_pkg::*;
    logic [2:0] age;      // Edges since reset, saturating
    logic       prev_bad; // Previous symbol carried an error
    wire logic  err_cls = tx_sym_class inside {SYM_INVALID, SYM_HALT};
    wire logic  lo = line_coding != COD_PAM5;
    // One pair each way, crossed by mdix, never the same pair
    wire logic  pair_ok = !line_pair_c_en && !line_pair_d_en &&
        line_pair_a_tx_pos_en != line_pair_b_tx_pos_en &&
        line_pair_a_tx_pos_en == line_pair_b_rx_pos_sel &&
        line_pair_a_rx_pos_sel != line_pair_b_rx_pos_sel;
    // Pair outputs hold their reset zeros only until the first edge after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) age <= 3'h0;
        else if (age != 3'h7) age <= age + 3'h1;
    end
    // Error history for the halt chain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) prev_bad <= 1'b0;
        else if (tx_sym_valid) prev_bad <= err_cls;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_gig_run;
        (line_coding == COD_PAM5) [*3];
    endsequence
    property p_pair_lo; age == 3'h7 && lo |-> pair_ok; endproperty
    property p_pair_hi;
        line_coding == COD_PAM5 |-> line_pair_c_en && line_pair_d_en;
    endproperty
    property p_dv; !mii_rx_dv |-> mii_rxd == 8'h00 && !mii_rx_er; endproperty
    property p_nib; lo |-> mii_rxd[7:4] == 4'h0; endproperty
    property p_rxer10; line_coding == COD_MANCHESTER |-> !mii_rx_er; endproperty
    property p_tx10;
        line_coding == COD_MANCHESTER && tx_sym_valid |-> !err_cls;
    endproperty
    property p_halt;
        line_coding == COD_MLT3 && tx_sym_valid && err_cls |->
            (tx_sym_class == SYM_HALT) == prev_bad;
    endproperty
    property p_gig_err;
        line_coding == COD_PAM5 && tx_sym_valid |-> tx_sym_class != SYM_HALT;
    endproperty
    property p_idle;
        tx_sym_valid && tx_sym_class == SYM_IDLE |-> tx_sym_data == 8'h00;
    endproperty
    property p_rxclk_gig; s_gig_run |-> $changed(mii_rx_clk); endproperty
    property p_rxclk_100;
        line_coding == COD_MLT3 && $past(line_coding, 6) == COD_MLT3 &&
            $rose(mii_rx_clk) |-> !$past(mii_rx_clk, 4) && $past(mii_rx_clk, 5);
    endproperty
    property p_txclk_gig;
        s_gig_run |-> !mii_tx_clk;
    endproperty
    a_pair_lo: assert property (p_pair_lo) else $error("pair use");
    a_pair_hi: assert property (p_pair_hi) else $error("pair cd");
    a_dv: assert property (p_dv) else $error("rx idle lines");
    a_nib: assert property (p_nib) else $error("rx nibble pad");
    a_rxer10: assert property (p_rxer10) else $error("rx err at 10");
    a_tx10: assert property (p_tx10) else $error("tx err at 10");
    a_halt: assert property (p_halt) else $error("halt chain");
    a_gig_err: assert property (p_gig_err) else $error("gig err");
    a_idle: assert property (p_idle) else $error("idle data");
    a_rxclk_gig: assert property (p_rxclk_gig) else $error("rx clk");
    a_rxclk_100: assert property (p_rxclk_100) else $error("rx clk");
    a_txclk_gig: assert property (p_txclk_gig) else $error("tx clk");
endmodule : mgp_phy_properties

bind mgp_mii_phy mgp_phy_properties u_props (.clk, .reset_n, .line_coding,
    .line_pair_a_tx_pos_en, .line_pair_b_tx_pos_en, .line_pair_a_rx_pos_sel,
    .line_pair_b_rx_pos_sel, .line_pair_c_en, .line_pair_d_en, .mii_tx_clk,
    .mii_rx_clk, .mii_rxd, .mii_rx_dv, .mii_rx_er, .tx_sym_valid,
    .tx_sym_data, .tx_sym_class);

//--- tb/tb_top.sv
// Self-checking bench for the PHY-side MII/GMII block.
// Assumes the MAC model and the port checker are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import mgp_pkg::*;
    logic clk, reset_n, an_enable, an_done, mdix, gig, nx_en, nx_er;
    logic rx_sym_valid, rx_sym_err, mii_tx_en, mii_tx_er, gtx_clk;
    logic [1:0] speed_forced, an_speed;
    logic [7:0] rx_sym_data, nx_txd, mii_txd, mii_rxd, tx_sym_data;
    logic mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_rx_er, rx_sym_ready;
    logic tx_sym_valid, line_pair_c_en, line_pair_d_en;
    logic line_pair_a_tx_pos_en, line_pair_b_tx_pos_en;
    logic line_pair_a_rx_pos_sel, line_pair_b_rx_pos_sel;
    mgp_sym_t    tx_sym_class;
    mgp_coding_t line_coding;
    logic [8:0]  rx_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    mgp_coding_t cod_t[3] = '{COD_MANCHESTER, COD_MLT3, COD_PAM5};
    int rx_h[3] = '{40, 4, 1}; // Half periods in clk cycles
    int tx_h[3] = '{40, 4, 0}; // Zero: held still at 1000
    mgp_mii_phy DUT (.clk, .reset_n, .speed_forced, .an_enable, .an_done,
        .an_speed, .mdix, .gtx_clk, .mii_txd, .mii_tx_en, .mii_tx_er,
        .mii_tx_clk, .mii_rx_clk, .mii_rxd, .mii_rx_dv, .mii_rx_er,
        .rx_sym_valid, .rx_sym_data, .rx_sym_err, .rx_sym_ready,
        .tx_sym_valid, .tx_sym_data, .tx_sym_class, .line_coding,
        .line_pair_a_tx_pos_en, .line_pair_b_tx_pos_en,
        .line_pair_a_rx_pos_sel, .line_pair_b_rx_pos_sel,
        .line_pair_c_en, .line_pair_d_en);
    mgp_mac_model u_mac (.mii_tx_clk, .gig, .nx_txd, .nx_en, .nx_er,
        .gtx_clk, .mii_txd, .mii_tx_en, .mii_tx_er);
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    // Strobe receive words as the MAC would
    always @(posedge mii_rx_clk) begin
        if (mii_rx_dv === 1'b1) rx_q.push_back({mii_rx_er, mii_rxd});
    end
    task automatic end_sim;
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // Hang guard, far above the few thousand cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            end_sim;
        end
    end
    task automatic check(input string what, input logic [8:0] exp, got);
        cmp_count++;
        if (exp !== got) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : check
    task automatic set_speed(input logic [1:0] code, input logic m);
        @(negedge clk);
        speed_forced = code;
        mdix = m;
        gig = code[1];
        repeat (8) @(negedge clk);
    endtask : set_speed
    // Half period of a clock output, zero if it never moves
    task automatic measure(input logic use_rx, output logic [8:0] n);
        logic p, s;
        int k;
        k = 0;
        n = 9'h0;
        @(posedge clk);
        #1;
        p = use_rx ? mii_rx_clk : mii_tx_clk;
        for (int i = 0; i < 300 && k < 2; i++) begin
            @(posedge clk);
            #1;
            s = use_rx ? mii_rx_clk : mii_tx_clk;
            if (s !== p) k++;
            if (k == 1) n++;
            p = s;
        end
    endtask : measure
    task automatic t_speed;
        logic [8:0] n;
        for (int c = 0; c < 6; c++) begin
            set_speed(c[2:1], c[0]);
            check("coding", 9'(cod_t[c / 2]), 9'(line_coding));
            if (c[2]) check("pairs_cd", 9'h3f,
                {line_pair_a_tx_pos_en, line_pair_b_tx_pos_en,
                 line_pair_a_rx_pos_sel, line_pair_b_rx_pos_sel,
                 line_pair_c_en, line_pair_d_en});
            else check("pairs", {3'h0, ~c[0], c[0], c[0], ~c[0], 2'h0},
                {line_pair_a_tx_pos_en, line_pair_b_tx_pos_en,
                 line_pair_a_rx_pos_sel, line_pair_b_rx_pos_sel,
                 line_pair_c_en, line_pair_d_en});
            measure(1'b1, n);
            check("rx_half", 9'(rx_h[c / 2]), n);
            measure(1'b0, n);
            check("tx_half", 9'(tx_h[c / 2]), n);
        end
    endtask : t_speed
    // Negotiated speed only counts once negotiation is done
    task automatic t_an;
        set_speed(2'h0, 1'b0);
        an_enable = 1'b1;
        an_speed = 2'h1;
        repeat (8) @(negedge clk);
        check("an_wait", COD_MANCHESTER, line_coding);
        an_done = 1'b1;
        repeat (8) @(negedge clk);
        check("an_done", COD_MLT3, line_coding);
        an_enable = 1'b0;
        an_done = 1'b0;
    endtask : t_an
    task automatic wait_valid;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (tx_sym_valid === 1'b1) break;
        end
        check("tx_valid", 9'h1, {8'h0, tx_sym_valid});
    endtask : wait_valid
    task automatic sym(input logic en, er, input logic [7:0] d,
                       input mgp_sym_t cls, input logic [7:0] ed);
        wait_valid;
        @(negedge clk);
        nx_en = en;
        nx_er = er;
        nx_txd = d;
        wait_valid;
        check("tx_class", cls, tx_sym_class);
        if (cls inside {SYM_DATA, SYM_IDLE})
            check("tx_data", ed, tx_sym_data);
    endtask : sym
    task automatic t_tx;
        set_speed(2'h1, 1'b0);
        sym(1'b1, 1'b0, 8'hf6, SYM_DATA, 8'h06);
        sym(1'b1, 1'b1, 8'h03, SYM_INVALID, 8'h00);
        sym(1'b1, 1'b1, 8'h03, SYM_HALT, 8'h00);
        sym(1'b1, 1'b1, 8'h03, SYM_HALT, 8'h00);
        sym(1'b1, 1'b0, 8'h09, SYM_DATA, 8'h09);
        sym(1'b0, 1'b0, 8'h5a, SYM_IDLE, 8'h00);
        set_speed(2'h0, 1'b0);
        sym(1'b1, 1'b1, 8'h0c, SYM_DATA, 8'h0c);
        sym(1'b0, 1'b0, 8'h0c, SYM_IDLE, 8'h00);
        set_speed(2'h2, 1'b0);
        sym(1'b1, 1'b0, 8'ha5, SYM_DATA, 8'ha5);
        sym(1'b1, 1'b1, 8'h11, SYM_INVALID, 8'h00);
        sym(1'b1, 1'b1, 8'h22, SYM_INVALID, 8'h00);
        sym(1'b0, 1'b0, 8'h77, SYM_IDLE, 8'h00);
    endtask : t_tx
    // Offer one recovered byte; released lines show garbage
    task automatic rx_send(input logic [7:0] d, input logic e);
        @(negedge clk);
        for (int i = 0; i < 900 && rx_sym_ready !== 1'b1; i++) @(negedge clk);
        check("rx_ready", 9'h1, {8'h0, rx_sym_ready});
        rx_sym_valid = 1'b1;
        rx_sym_data = d;
        rx_sym_err = e;
        @(negedge clk);
        rx_sym_valid = 1'b0;
        rx_sym_data = ~d;
        rx_sym_err = ~e;
    endtask : rx_send
    task automatic t_rx;
        int n;
        logic [7:0] b;
        for (int c = 0; c < 3; c++) begin
            set_speed(c[1:0] | {1'b0, c[1]}, 1'b1);
            rx_q.delete();
            rx_send(8'ha5, 1'b1);
            rx_send(8'h3c, 1'b0);
            n = (c == 2) ? 2 : 4;
            repeat (500) @(posedge clk);
            check("rx_count", 9'(n), 9'(rx_q.size()));
            for (int i = 0; i < n; i++) begin
                b = (i < n / 2) ? 8'ha5 : 8'h3c;
                if (c != 2) b = i[0] ? {4'h0, b[7:4]} : {4'h0, b[3:0]};
                check("rx_word", {i < n / 2 && c != 0, b},
                    rx_q[i]);
            end
        end
    endtask : t_rx
    initial begin
        {reset_n, an_enable, an_done, mdix, gig, nx_en, nx_er} = '0;
        {rx_sym_valid, rx_sym_err, speed_forced, an_speed} = '0;
        {rx_sym_data, nx_txd} = '0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        t_speed;
        t_an;
        t_tx;
        t_rx;
        end_sim;
    end
endmodule : tb_top
